// ===== hw/sadc_consts.vh
// constants for the software adc compare control block
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
`define SADC_ADDR_CTRL_HIGH 8'he8
`define SADC_ADDR_CODE_LOW 8'h98
`define SADC_RESET_CTRL 8'h00
`define SADC_RESET_LOW 4'h0
`define SADC_BIT_RESULT 7
`define SADC_BIT_SEL_HIGH 6
`define SADC_BIT_SEL_LOW 5
`define SADC_BIT_START 4
`define SADC_SEL_FOURTH 2'h0
`define SADC_SEL_FIRST 2'h1
`define SADC_SEL_SECOND 2'h2
`define SADC_SEL_THIRD 2'h3
`define SADC_SETTLE_CYCLES 2'h1
`endif

// ===== hw/sadc_control.v
// software adc: dac code, input selector, start bit and comparator result
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"
module sadc_control (
   // clock and reset
   input wire clk_sys_in,
   input wire rst_b_in,
   // special function register access
   input wire [7:0] sfr_addr_in,
   input wire sfr_wr_in,
   input wire sfr_rd_in,
   input wire [7:0] sfr_wdata_in,
   output reg [7:0] sfr_rdata_out,
   // analog front end
   output reg [3:0] analog_input_enable_out,
   output reg [1:0] input_select_out,
   output reg [7:0] dac_code_out,
   output reg compare_result_valid_out,
   input wire compare_raw_in
);

////////////////////////////////////////////////////////////////////////////////
reg [1:0] sel_r;
reg start_r;
reg [3:0] code_high_r;
reg [3:0] code_low_r;
reg result_r;
reg sync1_r;
reg sync2_r;
function [3:0] sadc_onehot;
   input [1:0] sel;
   begin
      case (sel)
         `SADC_SEL_FOURTH: sadc_onehot = 4'h8;
         `SADC_SEL_FIRST: sadc_onehot = 4'h1;
         `SADC_SEL_SECOND: sadc_onehot = 4'h2;
         `SADC_SEL_THIRD: sadc_onehot = 4'h4;
         default: sadc_onehot = 4'h0;
      endcase
   end
endfunction

wire wr_ctrl = sfr_wr_in && (sfr_addr_in == `SADC_ADDR_CTRL_HIGH);
wire wr_low = sfr_wr_in && (sfr_addr_in == `SADC_ADDR_CODE_LOW);
// a fresh start write restarts the one-cycle wait for a valid result
wire wr_start = wr_ctrl && sfr_wdata_in[`SADC_BIT_START];

////////////////////////////////////////////////////////////////////////////////
// register file
always @(posedge clk_sys_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      sel_r <= 2'h0;
      start_r <= 1'b0;
      code_high_r <= 4'h0;
      code_low_r <= `SADC_RESET_LOW;
   end else begin
      if (wr_ctrl) begin
         sel_r <= sfr_wdata_in[`SADC_BIT_SEL_HIGH:`SADC_BIT_SEL_LOW];
         start_r <= sfr_wdata_in[`SADC_BIT_START];
         code_high_r <= sfr_wdata_in[3:0];
      end
      if (wr_low) begin
         code_low_r <= sfr_wdata_in[3:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// comparator sampling: synchronised through two flops, then copied into result_r every cycle while start_r is set
always @(posedge clk_sys_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      result_r <= 1'b0;
   end else begin
      sync1_r <= compare_raw_in;
      sync2_r <= sync1_r;
      if (start_r) begin
         result_r <= sync2_r;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
always @(posedge clk_sys_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      analog_input_enable_out <= 4'h0;
      input_select_out <= 2'h0;
      dac_code_out <= 8'h00;
      compare_result_valid_out <= 1'b0;
      sfr_rdata_out <= 8'h00;
   end else begin
      analog_input_enable_out <= sadc_onehot(sel_r);
      input_select_out <= sel_r;
      dac_code_out <= {code_high_r, code_low_r};
      compare_result_valid_out <= start_r && !wr_start;
      if (sfr_rd_in && sfr_addr_in == `SADC_ADDR_CTRL_HIGH) begin
         sfr_rdata_out <= {result_r, sel_r, start_r, code_high_r};
      end else if (sfr_rd_in && sfr_addr_in == `SADC_ADDR_CODE_LOW) begin
         sfr_rdata_out <= {4'h0, code_low_r};
      end else begin
         sfr_rdata_out <= 8'h00;
      end
   end
end

endmodule
`default_nettype wire

// ===== verif/sadc_properties.sv
// assertions for the software adc compare block
`timescale 1ns/1ps
`default_nettype none
module sadc_properties (
   input wire logic clk_sys_in, rst_b_in, sfr_wr_in, sfr_rd_in, compare_result_valid_out,
   input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, dac_code_out,
   input wire logic [3:0] analog_input_enable_out);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   sequence hi_wr;
      sfr_wr_in && sfr_addr_in == 8'he8;
   endsequence
   sel_route_a: assert property (hi_wr |=> ##1
      analog_input_enable_out == 4'h1 << ($past(sfr_wdata_in[6:5], 2) + 2'h3)) else $error("route");
   code_high_a: assert property (hi_wr |=> ##1
      dac_code_out[7:4] == $past(sfr_wdata_in[3:0], 2)) else $error("high nibble");
   code_low_a: assert property (sfr_wr_in && sfr_addr_in == 8'h98 |=> ##1
      dac_code_out[3:0] == $past(sfr_wdata_in[3:0], 2)) else $error("low nibble");
   start_valid_a: assert property (hi_wr ##0 sfr_wdata_in[4] |=> ##1
      compare_result_valid_out) else $error("valid late");
   low_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'h98 |=>
      sfr_rdata_out[7:4] == 4'h0) else $error("low upper bits");
endmodule
bind sadc_control sadc_properties chk (.*);
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the software adc compare block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys_in = 0, rst_b_in = 0, sfr_wr_in = 0, sfr_rd_in = 0, compare_raw_in = 0;
   logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, got;
   wire [7:0] sfr_rdata_out, dac_code_out;
   wire [3:0] analog_input_enable_out;
   wire [1:0] input_select_out;
   wire compare_result_valid_out;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   // ctrl, low, dac code, routed input
   logic [31:0] rows [4] = '{32'h1ff3f308, 32'h2a05a501, 32'h445e4e02, 32'h70090904};
   sadc_control dut (.*);
   task automatic chk(input logic [7:0] s, e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %0t %h %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d);
      sfr_wr_in <= w;
      sfr_rd_in <= !w;
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      @(posedge clk_sys_in);
      sfr_wr_in <= 0;
      sfr_rd_in <= 0;
      #1 got = sfr_rdata_out;
      @(posedge clk_sys_in);
   endtask
   task automatic close_out;
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial forever #20 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         close_out;
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_b_in <= 1;
      compare_raw_in <= 1;
      foreach (rows[i]) begin
         acc(1, 8'he8, rows[i][31:24] & 8'hef);
         acc(1, 8'he8, rows[i][31:24]);
         acc(1, 8'h98, rows[i][23:16]);
         repeat (3) @(posedge clk_sys_in);
         chk(dac_code_out, rows[i][15:8]);
         chk({4'h0, analog_input_enable_out}, rows[i][7:0]);
         chk({6'h0, input_select_out}, {6'h0, rows[i][30:29]});
         chk({7'h0, compare_result_valid_out}, {7'h0, rows[i][28]});
         acc(0, 8'he8, 0);
         chk(got, {1'b1, rows[i][30:24]});
         acc(0, 8'h98, 0);
         chk(got, {4'h0, rows[i][19:16]});
      end
      acc(0, 8'h55, 0);
      chk(got, 8'h00);
      rst_b_in <= 0;
      @(posedge clk_sys_in);
      rst_b_in <= 1;
      acc(0, 8'he8, 0);
      chk(got, 8'h00);
      chk(dac_code_out, 8'h00);
      close_out;
   end
endmodule
`default_nettype wire
